// *** hdl/tpu_pkg.sv ***
package tpu_pkg;
  localparam int NCH = 2;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_SC = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CNT = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_MOD = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_PIN = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_CH0_SC = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_CH0_V = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_CH_STRIDE = 6'h08;
  localparam int SC_CLKS_LSB = 3;
  localparam int SC_PS_LSB = 0;
  localparam int CSC_MS_LSB = 4;
  localparam int CSC_ELS_LSB = 2;
  localparam int CSC_PU_BIT = 0;
  localparam int CSC_FLAG_BIT = 7;
  localparam logic [1:0] CLKS_OFF = 2'h0;
  localparam logic [1:0] CLKS_BUS = 2'h1;
  localparam logic [1:0] CLKS_EXT = 2'h3;
  localparam logic [7:0] SC_RST = 8'h00;
  localparam logic [7:0] CSC_RST = 8'h00;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] CV_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int EXT_CH = 0;
  typedef enum logic [1:0] {TPU_OFF, TPU_CAPT, TPU_COMP, TPU_PWM} tpu_chmode_t;
  typedef struct packed {
    logic [NCH-1:0] oe;
    logic [NCH-1:0] o;
    logic [NCH-1:0] pu;
    logic [NCH-1:0] own;
  } tpu_pin_t;
endpackage

// *** hdl/tpu_ext_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpu_ext_sync
  import tpu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_rise
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic lvl_q;
  logic lvl_d;
  logic rise_q;
  logic rise_d;

  always_comb begin
    sync_d = {sync_q[1:0], i_pin};
    lvl_d = lvl_q;
    rise_d = 1'b0;
    // Only stages 2 and 3 are compared; stage 1 may be metastable
    if (sync_q[1] == sync_q[2]) begin
      lvl_d = sync_q[2];
      rise_d = sync_q[2] & ~lvl_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync_q <= 3'h0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign o_rise = rise_q;

  one_wide_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rise |=> !o_rise) else $error("count enable wider than one cycle");
endmodule // tpu_ext_sync
`default_nettype wire

// *** hdl/tpu_timer.sv ***
// Operation
// - Each channel picks capture, compare or PWM on its own, independent of the others.
// - A channel configured as a timer input can switch on a passive pullup on its pin.
// - After reset the timer is off and every pin is a general-purpose input, pullup off.
// - Clock select 1:1 drives the prescaler and counter from the external clock pin.
// - The external clock passes a bus-clock synchronizer before any timer logic.
// - A channel whose pin is the external clock never uses the pin; compare still runs.
// - While the timer owns a pin, port data and direction settings are ignored.
// - A channel needing no pin function hands the pin back to general-purpose I/O.
// - Each channel has its own 8-bit control and 16-bit value, apart from unit registers.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tpu_timer
  import tpu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_ext_clk,
  input wire logic [NCH-1:0] i_ch_pin,
  input wire logic [NCH-1:0] i_gpio_out,
  input wire logic [NCH-1:0] i_gpio_dir,
  output logic [NCH-1:0] o_ch_pin_o,
  output logic [NCH-1:0] o_ch_pin_oe,
  output logic [NCH-1:0] o_ch_pin_pu,
  output logic [NCH-1:0] o_ch_pin_own
);
  function automatic int ch_of(input logic [ADDR_W-1:0] a);
    return int'((a - OFF_CH0_SC) >> 3);
  endfunction
  function automatic logic is_ch(input logic [ADDR_W-1:0] a);
    return (a >= OFF_CH0_SC) && (a < OFF_CH0_SC + 6'(NCH * 8));
  endfunction
  function automatic tpu_chmode_t mode_of(input logic [7:0] csc);
    logic [1:0] ms;
    logic [1:0] els;
    ms = csc[CSC_MS_LSB +: 2];
    els = csc[CSC_ELS_LSB +: 2];
    if (ms == 2'h0) return (els == 2'h0) ? TPU_OFF : TPU_CAPT;
    if (ms == 2'h1) return TPU_COMP;
    return TPU_PWM;
  endfunction

  // Register file
  logic [7:0] sc_q, sc_d;
  logic [15:0] mod_q, mod_d;
  logic [15:0] cnt_q, cnt_d;
  logic [6:0] pre_q, pre_d;
  logic [7:0] csc_q [NCH], csc_d [NCH];
  logic [15:0] cv_q [NCH], cv_d [NCH];
  logic [NCH-1:0] chout_q, chout_d;
  logic [NCH-1:0] pin_q [3];
  logic [NCH-1:0] pin_d [3];
  logic [NCH-1:0] plvl_q, plvl_d;
  // AXI state
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;

  logic ext_rise, tick, pre_hit, wr_fire;
  logic [1:0] clks;
  logic [NCH-1:0] ext_claim, ch_ev;

  tpu_ext_sync u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_ext_clk),
    .o_rise(ext_rise)
  );

  assign clks = sc_q[SC_CLKS_LSB +: 2];
  always_comb begin
    unique case (clks)
      CLKS_BUS: tick = 1'b1;
      CLKS_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end
  assign pre_hit = tick && (pre_q == ~(7'h7F << sc_q[SC_PS_LSB +: 3]));
  assign ext_claim = (clks == CLKS_EXT) ? (NCH'(1) << EXT_CH) : '0;
  assign wr_fire = aw_q && w_q && !bv_q;

  always_comb begin
    sc_d = sc_q;
    mod_d = mod_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    chout_d = chout_q;
    pin_d[0] = i_ch_pin;
    pin_d[1] = pin_q[0];
    pin_d[2] = pin_q[1];
    plvl_d = plvl_q;
    ch_ev = '0;
    for (int i = 0; i < NCH; i++) begin
      csc_d[i] = csc_q[i];
      cv_d[i] = cv_q[i];
    end
    if (tick) begin
      pre_d = pre_hit ? 7'h00 : pre_q + 7'h01;
    end
    if (pre_hit) begin
      cnt_d = (cnt_q == mod_q && mod_q != 16'h0000) ? 16'h0000 : cnt_q + 16'h0001;
      if (cnt_d == 16'h0000) begin
        sc_d[7] = 1'b1;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      // Capture inputs use the 2/3-agreement filter like the clock pin
      if (pin_q[1][i] == pin_q[2][i]) begin
        plvl_d[i] = pin_q[2][i];
      end
      unique case (mode_of(csc_q[i]))
        TPU_CAPT: begin
          if (!ext_claim[i] && plvl_d[i] != plvl_q[i] &&
              csc_q[i][CSC_ELS_LSB + (plvl_d[i] ? 0 : 1)]) begin
            cv_d[i] = cnt_q;
            csc_d[i][CSC_FLAG_BIT] = 1'b1;
            ch_ev[i] = 1'b1;
          end
        end
        TPU_COMP: begin
          if (pre_hit && cnt_q == cv_q[i]) begin
            csc_d[i][CSC_FLAG_BIT] = 1'b1;
            ch_ev[i] = 1'b1;
            unique case (csc_q[i][CSC_ELS_LSB +: 2])
              2'h1: chout_d[i] = ~chout_q[i];
              2'h2: chout_d[i] = 1'b0;
              2'h3: chout_d[i] = 1'b1;
              default: chout_d[i] = chout_q[i];
            endcase
          end
        end
        TPU_PWM: begin
          if (pre_hit) begin
            if (cnt_d == 16'h0000) chout_d[i] = ~csc_q[i][CSC_ELS_LSB];
            else if (cnt_d == cv_q[i]) chout_d[i] = csc_q[i][CSC_ELS_LSB];
          end
        end
        default: chout_d[i] = 1'b0;
      endcase
    end
    if (wr_fire) begin
      if (awa_q == OFF_SC && ws_q[0]) begin
        sc_d = wd_q[7:0] & 8'h7F;
        sc_d[7] = (sc_q[7] && wd_q[7]) || (pre_hit && cnt_d == 16'h0000);
      end else if (awa_q == OFF_CNT) begin
        cnt_d = 16'h0000;
        pre_d = 7'h00;
      end else if (awa_q == OFF_MOD) begin
        if (ws_q[0]) mod_d[7:0] = wd_q[7:0];
        if (ws_q[1]) mod_d[15:8] = wd_q[15:8];
      end else if (is_ch(awa_q)) begin
        if (awa_q[2] == 1'b0) begin
          if (ws_q[0]) begin
            csc_d[ch_of(awa_q)][6:0] = wd_q[6:0];
            // Write 0 clears the flag, but a same-cycle event keeps it set
            if (!wd_q[7]) csc_d[ch_of(awa_q)][7] = ch_ev[ch_of(awa_q)];
          end
        end else begin
          if (ws_q[0]) cv_d[ch_of(awa_q)][7:0] = wd_q[7:0];
          if (ws_q[1]) cv_d[ch_of(awa_q)][15:8] = wd_q[15:8];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // Timer owns the pin only when its mode needs it
      o_ch_pin_own[i] = (mode_of(csc_q[i]) != TPU_OFF) &&
                        (csc_q[i][CSC_ELS_LSB +: 2] != 2'h0) && !ext_claim[i];
      if (o_ch_pin_own[i]) begin
        o_ch_pin_oe[i] = (mode_of(csc_q[i]) != TPU_CAPT);
        o_ch_pin_o[i] = chout_q[i];
        o_ch_pin_pu[i] = (mode_of(csc_q[i]) == TPU_CAPT) && csc_q[i][CSC_PU_BIT];
      end else begin
        o_ch_pin_oe[i] = i_gpio_dir[i] && !ext_claim[i];
        o_ch_pin_o[i] = i_gpio_out[i];
        o_ch_pin_pu[i] = 1'b0;
      end
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    bv_d = bv_q;
    rv_d = rv_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    br_d = br_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (i_awvalid && o_awready) begin
      aw_d = 1'b1;
      awa_d = {i_awaddr[ADDR_W-1:2], 2'h0};
    end
    if (i_wvalid && o_wready) begin
      w_d = 1'b1;
      wd_d = i_wdata;
      ws_d = i_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = (awa_q <= OFF_MOD || is_ch(awa_q)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bv_q && i_bready) bv_d = 1'b0;
    if (i_arvalid && o_arready) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      unique case ({i_araddr[ADDR_W-1:2], 2'h0})
        OFF_SC: rd_d = {24'h0, sc_q};
        OFF_CNT: rd_d = {16'h0, cnt_q};
        OFF_MOD: rd_d = {16'h0, mod_q};
        OFF_PIN: rd_d = {24'h0, 2'(o_ch_pin_own), 2'(plvl_q), 4'h0};
        default: begin
          if (is_ch({i_araddr[ADDR_W-1:2], 2'h0})) begin
            rd_d = i_araddr[2] ? {16'h0, cv_q[ch_of({i_araddr[ADDR_W-1:2], 2'h0})]}
                               : {24'h0, csc_q[ch_of({i_araddr[ADDR_W-1:2], 2'h0})]};
          end else begin
            rd_d = 32'h0;
            rr_d = RESP_SLVERR;
          end
        end
      endcase
    end
    if (rv_q && i_rready) rv_d = 1'b0;
  end

  assign o_awready = !aw_q && !bv_q;
  assign o_wready = !w_q && !bv_q;
  assign o_arready = !rv_q;
  assign o_bvalid = bv_q;
  assign o_bresp = br_q;
  assign o_rvalid = rv_q;
  assign o_rresp = rr_q;
  assign o_rdata = rd_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sc_q <= SC_RST;
      mod_q <= MOD_RST;
      cnt_q <= 16'h0000;
      pre_q <= 7'h00;
      chout_q <= '0;
      pin_q <= '{default: '0};
      plvl_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        csc_q[i] <= CSC_RST;
        cv_q[i] <= CV_RST;
      end
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      br_q <= RESP_OKAY;
      rr_q <= RESP_OKAY;
      rd_q <= 32'h0;
    end else begin
      sc_q <= sc_d;
      mod_q <= mod_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      chout_q <= chout_d;
      pin_q <= pin_d;
      plvl_q <= plvl_d;
      csc_q <= csc_d;
      cv_q <= cv_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
    end
  end

  sequence ext_edge_s;
    clks == CLKS_EXT && ext_rise && sc_q[SC_PS_LSB +: 3] == 3'h0;
  endsequence
  ext_drives_cnt_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ext_edge_s and !wr_fire |=> cnt_q != $past(cnt_q))
    else $error("external edge did not advance counter");
  ext_only_cnt_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clks == CLKS_EXT && !ext_rise && !wr_fire |=> cnt_q == $past(cnt_q))
    else $error("counter moved without external edge");
  ext_pin_free_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clks == CLKS_EXT |-> !o_ch_pin_own[EXT_CH] && !o_ch_pin_oe[EXT_CH])
    else $error("channel drives external clock pin");
  pin_owner_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_ch_pin_own[1] |-> o_ch_pin_o[1] == chout_q[1] || !o_ch_pin_oe[1])
    else $error("gpio data reached timer owned pin");
  pin_return_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    csc_q[1][CSC_ELS_LSB +: 2] == 2'h0 |-> !o_ch_pin_own[1] &&
    o_ch_pin_oe[1] == i_gpio_dir[1])
    else $error("idle channel kept its pin");
  pullup_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_ch_pin_pu[1] |-> mode_of(csc_q[1]) == TPU_CAPT && csc_q[1][CSC_PU_BIT])
    else $error("pullup on without capture input");
  reset_idle_a: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> sc_q == SC_RST && o_ch_pin_pu == '0 && o_ch_pin_own == '0)
    else $error("timer not idle after reset");
  chan_indep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !wr_fire |=> csc_q[1][6:0] == $past(csc_q[1][6:0]))
    else $error("channel control changed without a write");
endmodule // tpu_timer
`default_nettype wire

// *** sim/tpu_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpu_far_model
  import tpu_pkg::*;
(
  input wire logic i_clk,
  input wire logic [NCH-1:0] i_pin_o,
  input wire logic [NCH-1:0] i_pin_oe,
  input wire logic [NCH-1:0] i_pin_pu,
  output logic o_ext_clk,
  output logic [NCH-1:0] o_pin
);
  logic [NCH-1:0] idle_q = '0;
  initial o_ext_clk = 1'b0;
  // Undriven, unpulled pins wander so a stale level cannot pass
  always @(posedge i_clk) idle_q <= ~idle_q;
  assign o_pin = (i_pin_oe & i_pin_o) | (~i_pin_oe & (i_pin_pu | idle_q));
  // Each phase lasts over two bus periods, keeping the rate below a quarter
  task automatic send_edges(input int n);
    repeat (n) begin
      #(53 + $urandom_range(80)) o_ext_clk = 1'b1;
      #(53 + $urandom_range(80)) o_ext_clk = 1'b0;
    end
  endtask
endmodule // tpu_far_model
`default_nettype wire

// *** sim/timer_ext_clock_and_pins_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_ext_clock_and_pins_bench;
  import tpu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, ext_clk;
  logic [1:0] bresp, rresp, r, clks;
  logic [NCH-1:0] ch_pin, pin_o, pin_oe, pin_pu, pin_own, gpio_out = '0, gpio_dir = '0;
  logic [7:0] csc [NCH];
  logic [31:0] cv_exp [NCH];
  logic [1:0] clk_tab [3] = '{CLKS_OFF, CLKS_BUS, CLKS_EXT};
  int fails = 0;
  int checks_done = 0;
  int n;

  always #12.5 clk = ~clk;

  tpu_timer tpu_timer_inst (.i_clk(clk), .i_sys_rst(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_ext_clk(ext_clk), .i_ch_pin(ch_pin), .i_gpio_out(gpio_out), .i_gpio_dir(gpio_dir),
    .o_ch_pin_o(pin_o), .o_ch_pin_oe(pin_oe), .o_ch_pin_pu(pin_pu), .o_ch_pin_own(pin_own));

  tpu_far_model tpu_far_model_inst (.i_clk(clk), .i_pin_o(pin_o), .i_pin_oe(pin_oe),
    .i_pin_pu(pin_pu), .o_ext_clk(ext_clk), .o_pin(ch_pin));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic [NCH-1:0] exp,
                         input logic [NCH-1:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Expected pin ownership is worked out after the inputs of this edge have landed
  task automatic check_pins();
    logic [NCH-1:0] own, oe, pu;
    @(posedge clk);
    #1;
    for (int c = 0; c < NCH; c++) begin
      own[c] = csc[c][3:2] != 2'h0 && !(c == EXT_CH && clks == CLKS_EXT);
      oe[c] = own[c] ? csc[c][5:4] != 2'h0 : gpio_dir[c] && !(c == EXT_CH && clks == CLKS_EXT);
      pu[c] = own[c] && csc[c][5:4] == 2'h0 && csc[c][CSC_PU_BIT];
    end
    chk_pin("own", own, pin_own);
    chk_pin("oe", oe, pin_oe);
    chk_pin("pu", pu, pin_pu);
    chk_pin("gpio_o", gpio_out & ~own, pin_o & ~own);
    @(posedge clk);
  endtask

  initial begin
    #250000;
    fails++;
    stop_test();
  end

  initial begin
    void'($urandom(78));
    csc = '{default: 8'h00};
    clks = CLKS_OFF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_pins();
    foreach (clk_tab[i]) begin
      axi_read(i == 0 ? OFF_SC : ADDR_W'(OFF_CH0_SC + 8 * (i - 1)));
      chk_val("reset_ctrl", {24'h0, i == 0 ? SC_RST : CSC_RST}, d);
    end
    axi_read(6'h3C);
    chk_val("unmapped", {30'h0, RESP_SLVERR}, {d[29:0], r});
    $display("test reset done");
    for (int i = 0; i < NCH; i++) begin
      cv_exp[i] = $urandom;
      axi_write(ADDR_W'(OFF_CH0_V + 8 * i), cv_exp[i]);
      chk_val("wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
    end
    for (int i = 0; i < NCH; i++) begin
      axi_read(ADDR_W'(OFF_CH0_V + 8 * i));
      chk_val("width", {16'h0, cv_exp[i][15:0]}, d);
      chk_val("rd_resp", {30'h0, RESP_OKAY}, {30'h0, r});
    end
    axi_write(6'h3C, 32'h0);
    chk_val("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test widths done");
    for (int i = 0; i < 16; i++) begin
      clks = clk_tab[$urandom_range(2)];
      for (int c = 0; c < NCH; c++) begin
        csc[c] = {2'h0, 2'($urandom_range(3)), 2'($urandom_range(3)), 1'b0, 1'($urandom)};
      end
      if (i == 0) begin
        clks = CLKS_EXT;
        csc[EXT_CH] = 8'h15;
      end
      axi_write(OFF_SC, {27'h0, clks, 3'h0});
      for (int c = 0; c < NCH; c++) axi_write(ADDR_W'(OFF_CH0_SC + 8 * c), {24'h0, csc[c]});
      for (int c = 0; c < NCH; c++) begin
        axi_read(ADDR_W'(OFF_CH0_SC + 8 * c));
        chk_val("ch_ctrl", {24'h0, csc[c] & 8'h7F}, d & 32'h7F);
      end
      gpio_out <= NCH'($urandom);
      gpio_dir <= NCH'($urandom);
      check_pins();
    end
    $display("test pins done");
    csc = '{default: 8'h00};
    for (int c = 0; c < NCH; c++) axi_write(ADDR_W'(OFF_CH0_SC + 8 * c), 32'h0);
    axi_write(OFF_MOD, 32'h0000FFFF);
    clks = CLKS_EXT;
    axi_write(OFF_SC, {27'h0, CLKS_EXT, 3'h0});
    axi_write(OFF_CNT, 32'h0);
    n = 5 + $urandom_range(6);
    tpu_far_model_inst.send_edges(n);
    repeat (8) @(posedge clk);
    axi_read(OFF_CNT);
    chk_val("ext_count", 32'(n), d);
    clks = CLKS_OFF;
    axi_write(OFF_SC, 32'h0);
    tpu_far_model_inst.send_edges(3);
    repeat (8) @(posedge clk);
    axi_read(OFF_CNT);
    chk_val("stopped_count", 32'(n), d);
    $display("test ext clock done");
    stop_test();
  end
endmodule // timer_ext_clock_and_pins_bench
`default_nettype wire
